// File: src/mss_seq_top.sv
// Purpose: Start-up, ready notice, shutdown and hibernate sequencing.
// Assumes: All pad inputs synchronous to ref_clk; rst is the power cycle.
// Notes:   Shutdown timing bounds are parameters so a bench can shorten them.
//
// Contract
// - Enter reset at power-up; stay there while the reset pad is low.
// - Do not leave reset until the real-time oscillator reports ready.
// - With oscillator ready and pad high, go on and raise wake.
// - After initialization send link-state message one as the first message.
// - UART host port runs at 4800 bps by default.
// - On I2C send only when the bus is free or granted.
// - Toggle pin high enters hibernate; a later low returns full power.
// - After command shutdown, only a toggle pulse returns full power.
// - In hibernate all serial commands are ignored.
// - Shutdown takes between 10 ms and 900 ms; the code holds the 10 ms floor, but past 900 ms it only raises shutdown_late.
// - Stay in full power until the transmit queue has drained.
// - Last message before hibernate is link-state message zero.
// - Command settings are volatile and revert on power cycle.
// - Without straps the host port is SPI with NMEA format.
// - A port setup sentence changes host protocol and baud rate.
// - Binary message 222 sub 16 selects the satellite constellations.
// - Stored elements are checked by CRC-32 to detect corruption.
// - Wake is low in hibernate, high in full power.
`timescale 1ns/1ns
module mss_seq_top
    import mss_pkg::*;
#(
    parameter int unsigned SD_MIN = SD_MIN_CYC,
    parameter int unsigned SD_MAX = SD_MAX_CYC
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Power and reset pads
    input  wire logic        reset_pad_n,
    input  wire logic        rtc_ready,
    input  wire logic        power_toggle,
    output logic             wake_out,
    output logic             hibernate,
    output logic             shutdown_late,
    // Handshake pad straps
    input  wire logic        cts_level,
    input  wire logic        rts_level,
    // Firmware status
    input  wire logic        init_done,
    // Decoded host commands
    input  wire logic        cmd_valid,
    input  wire mss_cmd_t    cmd_kind,
    input  wire logic [7:0]  cmd_mid,
    input  wire logic [7:0]  cmd_sub,
    input  wire logic [19:0] cmd_arg,
    // Pending application messages (transmit queue head)
    input  wire logic [7:0]  app_data,
    input  wire logic        app_valid,
    output logic             app_ready,
    // Host port byte stream
    output logic [7:0]       host_tx_data,
    output logic             host_tx_valid,
    input  wire logic        host_tx_ready,
    input  wire logic        i2c_bus_grant,
    // Active settings
    output mss_port_t        host_port,
    output logic [17:0]      host_baud,
    output logic [3:0]       constel_mask,
    // Stored element integrity
    input  wire logic [7:0]  chk_data,
    input  wire logic        chk_valid,
    input  wire logic        chk_first,
    input  wire logic        chk_last,
    input  wire logic [31:0] chk_expect,
    output logic             chk_pass,
    output logic             integrity_fail
);
    // ********
    // State and storage
    // ********
    typedef enum logic [2:0] {
        ST_RESET, ST_INIT, ST_NOTICE, ST_RUN,
        ST_SD_DRAIN, ST_SD_FINAL, ST_SD_HOLD, ST_HIBERNATE
    } mss_state_t;

    typedef struct packed {
        mss_state_t  st;
        logic [7:0]  rst_cnt;
        logic [27:0] sd_cnt;
        logic        sd_by_cmd;
        logic        tog_q;
        logic        pulse_seen;
        logic        late;
        logic        msg_start;
        logic        msg_on;
        logic        fail;
        mss_port_t   port;
        logic [17:0] baud;
        logic [3:0]  constel;
    } mss_seq_st_t;

    mss_seq_st_t q, d;
    mss_msg_if   msg ();
    logic        crc_fail;
    logic        gate;
    logic        msg_phase;
    logic        app_phase;
    logic        cmd_ok;

    // ********
    // Message sender and integrity checker
    // ********
    mss_msg_tx u_msg (
        .ref_clk (ref_clk),
        .rst     (rst),
        .m       (msg)
    );

    mss_crc32 u_crc (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .data       (chk_data),
        .valid      (chk_valid),
        .first      (chk_first),
        .last       (chk_last),
        .expect_crc (chk_expect),
        .pass       (chk_pass),
        .fail       (crc_fail)
    );

    // ********
    // Host stream arbitration
    // ********
    // wait for I2C grant
    assign gate      = (q.port != PORT_I2C) || i2c_bus_grant;
    assign msg_phase = msg.busy;
    // Queue only flows once the notice is out, and never after final message starts
    assign app_phase = !msg.busy && (q.st == ST_RUN || q.st == ST_SD_DRAIN);

    assign msg.start    = q.msg_start;
    assign msg.on_value = q.msg_on;
    assign msg.ready    = host_tx_ready && gate;

    always_comb begin
        host_tx_data  = msg_phase ? msg.data : app_data;
        host_tx_valid = gate && (msg_phase ? msg.valid : (app_phase && app_valid));
        app_ready     = gate && app_phase && host_tx_ready;
    end

    // commands only in full power run
    assign cmd_ok = cmd_valid && (q.st == ST_RUN);

    // ********
    // Sequencer next state
    // ********
    always_comb begin
        d           = q;
        d.msg_start = 1'b0;
        d.tog_q     = power_toggle;
        // Sticky once any stored element fails its check
        if (crc_fail) d.fail = 1'b1;

        // pad low must last the least pulse before it counts
        if (!reset_pad_n) begin
            if (q.rst_cnt != 8'(RST_MIN_CYC)) d.rst_cnt = q.rst_cnt + 8'h01;
        end else begin
            d.rst_cnt = 8'h00;
        end

        // Shutdown timer runs from the request until hibernate
        if (q.st == ST_SD_DRAIN || q.st == ST_SD_FINAL || q.st == ST_SD_HOLD) begin
            if (q.sd_cnt != 28'(SD_MAX)) d.sd_cnt = q.sd_cnt + 28'h000_0001;
            // overrun of the upper bound is flagged
            if (q.sd_cnt == 28'(SD_MAX - 1)) d.late = 1'b1;
        end

        unique case (q.st)
            // hold in reset while pad low
            ST_RESET: begin
                if (reset_pad_n && rtc_ready) begin
                    d.st = ST_INIT;
                    if (cts_level && rts_level)        d.port = PORT_UART;
                    else if (!cts_level && !rts_level) d.port = PORT_I2C;
                    else                               d.port = PORT_SPI;
                end
            end
            ST_INIT: begin
                if (init_done) begin
                    d.st        = ST_NOTICE;
                    d.msg_start = 1'b1;
                    d.msg_on    = 1'b1;
                end
            end
            ST_NOTICE: begin
                if (msg.done) d.st = ST_RUN;
            end
            ST_RUN: begin
                if (power_toggle) begin
                    d.st        = ST_SD_DRAIN;
                    d.sd_by_cmd = 1'b0;
                    d.sd_cnt    = 28'h000_0000;
                end else if (cmd_ok) begin
                    unique case (cmd_kind)
                        CMD_NMEA_SHUTDOWN: begin
                            d.st        = ST_SD_DRAIN;
                            d.sd_by_cmd = 1'b1;
                            d.sd_cnt    = 28'h000_0000;
                        end
                        CMD_NMEA_PORT_SETUP: begin
                            if (cmd_arg[ARG_PORT_LSB +: 2] != 2'b11)
                                d.port = mss_port_t'(cmd_arg[ARG_PORT_LSB +: 2]);
                            d.baud = cmd_arg[ARG_BAUD_LSB +: 18];
                        end
                        CMD_BINARY: begin
                            if (cmd_mid == MID_SHUTDOWN) begin
                                d.st        = ST_SD_DRAIN;
                                d.sd_by_cmd = 1'b1;
                                d.sd_cnt    = 28'h000_0000;
                            end else if (cmd_mid == MID_CONSTEL && cmd_sub == SUB_CONSTEL) begin
                                d.constel = cmd_arg[3:0];
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_SD_DRAIN: begin
                if (!app_valid) begin
                    d.st        = ST_SD_FINAL;
                    d.msg_start = 1'b1;
                    d.msg_on    = 1'b0;
                end
            end
            ST_SD_FINAL: begin
                if (msg.done) d.st = ST_SD_HOLD;
            end
            // wake drops only after final message
            ST_SD_HOLD: begin
                if (q.sd_cnt >= 28'(SD_MIN - 1)) begin
                    d.st         = ST_HIBERNATE;
                    d.pulse_seen = 1'b0;
                end
            end
            ST_HIBERNATE: begin
                // low level returns after pin entry
                if (!q.sd_by_cmd) begin
                    if (!power_toggle) d.st = ST_INIT;
                end else begin
                    // rise then fall forms the pulse
                    if (power_toggle && !q.tog_q) d.pulse_seen = 1'b1;
                    if (q.pulse_seen && !power_toggle) d.st = ST_INIT;
                end
            end
        endcase

        // Pad reset overrides everything once the pulse is long enough
        if (d.rst_cnt == 8'(RST_MIN_CYC)) d.st = ST_RESET;
    end

    // ********
    // State register
    // ********
    // power cycle restores defaults
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q         <= '0;
            q.st      <= ST_RESET;
            q.port    <= PORT_SPI;
            q.baud    <= BAUD_DEFAULT;
            q.constel <= CONSTEL_DEFAULT;
        end else begin
            q <= d;
        end
    end

    // ********
    // Outputs
    // ********
    // wake reflects full power
    assign wake_out       = (q.st != ST_RESET) && (q.st != ST_HIBERNATE);
    assign hibernate      = (q.st == ST_HIBERNATE);
    assign shutdown_late  = q.late;
    assign integrity_fail = q.fail;
    assign host_port      = q.port;
    assign host_baud      = q.baud;
    assign constel_mask   = q.constel;
endmodule : mss_seq_top

// File: src/mss_pkg.sv
// Purpose: Shared constants and types for the start-up and hibernate sequencer.
// Assumes: 250 MHz ref_clk, synchronous active-high reset.
// Notes:   Times are given in their own unit; cycle counts derive from them.
package mss_pkg;
    // ********
    // Clock and timing
    // ********
    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned RST_MIN_NS  = 1000;
    localparam int unsigned SD_MIN_MS   = 10;
    localparam int unsigned SD_MAX_MS   = 900;
    localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SD_MIN_CYC  = SD_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned SD_MAX_CYC  = SD_MAX_MS * (CLK_HZ / 1000);

    // ********
    // Host port, commands and defaults
    // ********
    typedef enum logic [1:0] {PORT_UART, PORT_SPI, PORT_I2C} mss_port_t;
    typedef enum logic [1:0] {CMD_NMEA_SHUTDOWN, CMD_NMEA_PORT_SETUP, CMD_BINARY} mss_cmd_t;
    localparam logic [17:0] BAUD_DEFAULT    = 18'h0_12C0;  // 4800 bps
    localparam logic [3:0]  CONSTEL_DEFAULT = 4'h3;        // GPS + GLONASS
    localparam logic [7:0]  MID_SHUTDOWN    = 8'h00CD;     // 205
    localparam logic [7:0]  MID_CONSTEL     = 8'h00DE;     // 222
    localparam logic [7:0]  SUB_CONSTEL     = 8'h0010;     // 16
    localparam int unsigned ARG_PORT_LSB    = 18;
    localparam int unsigned ARG_BAUD_LSB    = 0;

    // ********
    // Link-state message text and integrity check
    // ********
    localparam int unsigned MSG_LEN      = 15;
    localparam logic [119:0] MSG_TEXT    = 120'h24_5053_5246_3135_302C_302A_3346_0D0A; // Value zero
    localparam logic [3:0]  MSG_IDX_VAL  = 4'h9;
    localparam logic [3:0]  MSG_IDX_CKS  = 4'hC;
    localparam logic [7:0]  CHR_ONE      = 8'h0031;
    localparam logic [7:0]  CHR_E        = 8'h0045;
    localparam logic [31:0] CRC_POLY     = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT     = 32'hFFFF_FFFF;
endpackage : mss_pkg

// File: src/mss_msg_if.sv
// Purpose: Carrier between the sequencer and its message sender.
// Assumes: One clock shared by both ends.
// Notes:   Byte stream uses valid/ready; start is a one-cycle pulse.
`timescale 1ns/1ns
interface mss_msg_if;
    logic       start;
    logic       on_value;
    logic       busy;
    logic       done;
    logic [7:0] data;
    logic       valid;
    logic       ready;

    // Sender drives the stream, controller drives the request
    modport sender (input start, input on_value, input ready,
                    output busy, output done, output data, output valid);
    modport ctrl   (output start, output on_value, output ready,
                    input busy, input done, input data, input valid);
endinterface : mss_msg_if

// File: src/mss_msg_tx.sv
// Purpose: Emits the link-state message, value one or zero, byte by byte.
// Assumes: Start only while idle.
// Notes:   Checksum differs only in its last hex digit between the two values.
`timescale 1ns/1ns
module mss_msg_tx
    import mss_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Message carrier
    mss_msg_if.sender m
);
    typedef struct packed {
        logic       busy;
        logic       done;
        logic       on_v;
        logic [3:0] idx;
        logic [7:0] data;
    } mss_tx_st_t;

    mss_tx_st_t q, d;

    // Text lookup with the value and checksum patched in
    function automatic logic [7:0] msg_chr(input logic [3:0] idx, input logic on_v);
        logic [7:0] c;
        c = MSG_TEXT[8*(MSG_LEN-1-int'(idx)) +: 8];
        if (on_v && idx == MSG_IDX_VAL) c = CHR_ONE;
        if (on_v && idx == MSG_IDX_CKS) c = CHR_E;
        return c;
    endfunction : msg_chr

    // Next state
    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (!q.busy && m.start) begin
            d.busy = 1'b1;
            d.on_v = m.on_value;
            d.idx  = 4'h0;
            d.data = msg_chr(4'h0, m.on_value);
        end else if (q.busy && m.ready) begin
            if (q.idx == 4'(MSG_LEN-1)) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end else begin
                d.idx  = q.idx + 4'h1;
                d.data = msg_chr(q.idx + 4'h1, q.on_v);
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) q <= '0;
        else     q <= d;
    end

    assign m.busy  = q.busy;
    assign m.done  = q.done;
    assign m.data  = q.data;
    assign m.valid = q.busy;
endmodule : mss_msg_tx

// File: src/mss_crc32.sv
// Purpose: Byte-serial CRC-32 check of one stored data element.
// Assumes: First and last may fall on the same byte.
// Notes:   Result is a one-cycle pulse after the last byte.
`timescale 1ns/1ns
module mss_crc32
    import mss_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Element stream
    input  wire logic [7:0]  data,
    input  wire logic        valid,
    input  wire logic        first,
    input  wire logic        last,
    input  wire logic [31:0] expect_crc,
    // Result pulses
    output logic             pass,
    output logic             fail
);
    typedef struct packed {
        logic [31:0] crc;
        logic        pass;
        logic        fail;
    } mss_crc_st_t;

    mss_crc_st_t q, d;

    // Reflected polynomial, eight bit steps per byte
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction : crc_byte

    always_comb begin
        logic [31:0] nc;
        nc     = crc_byte(first ? CRC_INIT : q.crc, data);
        d      = q;
        d.pass = 1'b0;
        d.fail = 1'b0;
        if (valid) begin
            d.crc = nc;
            if (last) begin
                d.pass = (~nc == expect_crc);
                d.fail = (~nc != expect_crc);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) q <= '{crc: CRC_INIT, pass: 1'b0, fail: 1'b0};
        else     q <= d;
    end

    assign pass = q.pass;
    assign fail = q.fail;
endmodule : mss_crc32

// File: testbench/mss_seq_props.sv
// Purpose: Port checks for the start-up and hibernate sequencer.
// Assumes: One clock, synchronous active-high rst.
// Notes:   Bound to every mss_seq_top at the foot of this file.
`timescale 1ns/1ns
module mss_seq_props
    import mss_pkg::*;
(
    // Clock, pads and state
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        reset_pad_n,
    input wire logic        rtc_ready,
    input wire logic        wake_out,
    input wire logic        hibernate,
    // Commands, stream and settings
    input wire logic        cmd_valid,
    input wire logic        host_tx_valid,
    input wire logic        i2c_bus_grant,
    input wire mss_port_t   host_port,
    input wire logic [17:0] host_baud,
    input wire logic [3:0]  constel_mask,
    // Integrity
    input wire logic        chk_valid,
    input wire logic        chk_last,
    input wire logic        chk_pass
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Low-pad run length; one cycle of slack over the forced-reset count
    logic [8:0] pad_low_q;
    always_ff @(posedge ref_clk) begin
        pad_low_q <= (rst || reset_pad_n) ? 9'h000 : pad_low_q + 9'(pad_low_q != 9'h1FF);
    end
    reset_clear_a: assert property ($fell(rst) |-> !wake_out && !hibernate)
        else $error("wake or hibernate set right after reset");
    pad_hold_a: assert property (pad_low_q >= 9'h0FB |-> !wake_out)
        else $error("wake high while reset pad held low");
    reset_defaults_a: assert property ($fell(rst) |-> host_port == PORT_SPI &&
        host_baud == BAUD_DEFAULT && constel_mask == CONSTEL_DEFAULT)
        else $error("settings not at defaults after reset");
    wake_cause_a: assert property ($rose(wake_out) && !$past(hibernate) |->
        $past(rtc_ready) && $past(reset_pad_n)) else $error("wake rose without rtc ready");
    state_excl_a: assert property (!(wake_out && hibernate))
        else $error("wake and hibernate both high");
    hib_entry_a: assert property ($rose(hibernate) |-> $fell(wake_out))
        else $error("hibernate entered without wake falling");
    hib_quiet_a: assert property (hibernate |-> !host_tx_valid)
        else $error("stream active in hibernate");
    hib_cmd_a: assert property (hibernate && cmd_valid |=>
        $stable(host_port) && $stable(constel_mask)) else $error("command taken in hibernate");
    i2c_hold_a: assert property (host_port == PORT_I2C && !i2c_bus_grant |-> !host_tx_valid)
        else $error("stream sent without bus grant");
    crc_pulse_a: assert property (chk_pass |-> $past(chk_valid) && $past(chk_last))
        else $error("check pass without a last byte");
    cover property ($rose(hibernate));
    cover property ($rose(wake_out));
    cover property (chk_pass);
endmodule : mss_seq_props

bind mss_seq_top mss_seq_props u_props (.*);

// File: testbench/mss_host_model.sv
// Purpose: Host controller pulling the sequencer's host byte stream.
// Assumes: Same clock as the sequencer.
// Notes:   Slow mode takes one byte in four to exercise back-pressure.
`timescale 1ns/1ns
module mss_host_model (
    // Clock and control
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       slow,
    input wire logic       clr,
    input wire logic       wake,
    // Byte stream
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    output logic           tx_ready
);
    logic [7:0] cap [0:31];
    int         n_cap;
    logic [1:0] ph_q;
    assign tx_ready = wake && (!slow || ph_q == 2'h3);
    // Accepted bytes kept in arrival order
    always_ff @(posedge ref_clk) begin
        ph_q <= rst ? 2'h0 : ph_q + 2'h1;
        if (rst || clr) begin
            n_cap <= 0;
        end else if (tx_valid && tx_ready) begin
            cap[n_cap[4:0]] <= tx_data;
            n_cap <= n_cap + 1;
        end
    end
endmodule : mss_host_model

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the start-up and hibernate sequencer.
// Assumes: Short shutdown bounds, SPI straps at start.
// Notes:   One task per scenario; expected text written out in full.
`timescale 1ns/1ns
module tb_top;
    import mss_pkg::*;
    localparam int unsigned SDMIN = 20;
    logic ref_clk = 1'b0, rst = 1'b1, reset_pad_n = 1'b1, cts_level = 1'b1, rts_level = 1'b0;
    logic rtc_ready = 1'b0, power_toggle = 1'b0, init_done = 1'b0, cmd_valid = 1'b0;
    logic app_valid = 1'b0, i2c_bus_grant = 1'b1, slow = 1'b0, clr = 1'b0;
    logic chk_valid = 1'b0, chk_first = 1'b0, chk_last = 1'b0;
    logic [7:0] cmd_mid = 8'h00, cmd_sub = 8'h00, app_data = 8'h00, chk_data = 8'h00;
    logic [19:0] cmd_arg = 20'h0_0000;
    logic [31:0] chk_expect = 32'h0000_0000;
    mss_cmd_t cmd_kind = CMD_NMEA_SHUTDOWN;
    logic wake_out, hibernate, shutdown_late, app_ready, host_tx_valid, host_tx_ready;
    logic chk_pass, integrity_fail;
    logic [7:0] host_tx_data;
    logic [17:0] host_baud;
    logic [3:0] constel_mask;
    mss_port_t host_port;
    logic [119:0] msg0, msg1;
    int fails, n_tests, i;
    mss_seq_top #(.SD_MIN(SDMIN), .SD_MAX(400)) dut (.*);
    mss_host_model host (.ref_clk(ref_clk), .rst(rst), .slow(slow), .clr(clr),
        .wake(wake_out), .tx_data(host_tx_data), .tx_valid(host_tx_valid),
        .tx_ready(host_tx_ready));
    // Compare and count; case compare, so an unknown matches only the same unknown
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (exp !== got) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic chk_msg(logic [119:0] t, int off);
        for (int k = 0; k < MSG_LEN; k++) begin
            chk("msg byte", 32'(t[119-8*k -: 8]), 32'(host.cap[off+k]));
        end
    endtask : chk_msg
    // Clear the capture before anything can be sent
    task automatic clear_cap();
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
    endtask : clear_cap
    task automatic wait_wake();
        for (i = 0; i < 20 && wake_out !== 1'b1; i++) @(posedge ref_clk);
        chk("wake", 32'h1, 32'(wake_out));
    endtask : wait_wake
    task automatic notice();
        for (i = 0; i < 400 && host.n_cap < 15; i++) @(posedge ref_clk);
        chk_msg(msg1, 0);
        repeat (4) @(posedge ref_clk);
        chk("count", 32'hF, 32'(host.n_cap));
    endtask : notice
    task automatic send_cmd(mss_cmd_t k, logic [7:0] mid, logic [19:0] arg);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_mid <= mid;
        cmd_sub <= SUB_CONSTEL;
        cmd_arg <= arg;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask : send_cmd
    task automatic t_startup();
        repeat (20) @(posedge ref_clk);
        chk("early wake", 32'h0, 32'(wake_out));
        rtc_ready <= 1'b1;
        wait_wake();
        chk("port", 32'(PORT_SPI), 32'(host_port));
        chk("baud", 32'(BAUD_DEFAULT), 32'(host_baud));
        slow <= 1'b1;
        init_done <= 1'b1;
        notice();
        slow <= 1'b0;
    endtask : t_startup
    task automatic t_cmds();
        send_cmd(CMD_NMEA_PORT_SETUP, 8'h00, {PORT_UART, 18'h0_2580});
        @(posedge ref_clk);
        chk("port", 32'(PORT_UART), 32'(host_port));
        chk("baud", 32'h0000_2580, 32'(host_baud));
        send_cmd(CMD_BINARY, MID_CONSTEL, 20'h0_0005);
        send_cmd(CMD_NMEA_PORT_SETUP, 8'h00, {2'h3, 18'h0_12C0});
        @(posedge ref_clk);
        chk("constel", 32'h0000_0005, 32'(constel_mask));
        chk("port kept", 32'(PORT_UART), 32'(host_port));
        send_cmd(CMD_NMEA_PORT_SETUP, 8'h00, {PORT_I2C, 18'h0_12C0});
        i2c_bus_grant <= 1'b0;
        clr <= 1'b1;
        app_data <= 8'h5A;
        app_valid <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("no grant", 32'h0, 32'(host_tx_valid));
        i2c_bus_grant <= 1'b1;
        for (i = 0; i < 50 && app_ready !== 1'b1; i++) @(posedge ref_clk);
        app_valid <= 1'b0;
        @(posedge ref_clk);
        chk("granted", 32'h0000_005A, 32'(host.cap[0]));
    endtask : t_cmds
    task automatic t_pin_sd();
        int n;
        clear_cap();
        power_toggle <= 1'b1;
        app_data <= 8'h41;
        app_valid <= 1'b1;
        for (n = 0; n < 3000 && hibernate !== 1'b1; n++) begin
            @(posedge ref_clk);
            if (app_ready === 1'b1) app_valid <= 1'b0;
        end
        chk("sd min", 32'h1, 32'(n >= SDMIN));
        chk("late", 32'h0, 32'(shutdown_late));
        chk("wake low", 32'h0, 32'(wake_out));
        chk("drained", 32'h0000_0041, 32'(host.cap[0]));
        chk_msg(msg0, 1);
        chk("count", 32'h0000_0010, 32'(host.n_cap));
        send_cmd(CMD_NMEA_PORT_SETUP, 8'h00, {PORT_UART, 18'h0_12C0});
        @(posedge ref_clk);
        chk("hib port", 32'(PORT_I2C), 32'(host_port));
        clear_cap();
        power_toggle <= 1'b0;
        wait_wake();
        notice();
    endtask : t_pin_sd
    task automatic t_cmd_sd(mss_cmd_t k, logic [7:0] mid);
        send_cmd(k, mid, 20'h0_0000);
        for (i = 0; i < 3000 && hibernate !== 1'b1; i++) @(posedge ref_clk);
        clear_cap();
        repeat (10) @(posedge ref_clk);
        chk("hib held", 32'h1, 32'(hibernate));
        power_toggle <= 1'b1;
        repeat (3) @(posedge ref_clk);
        power_toggle <= 1'b0;
        wait_wake();
        notice();
    endtask : t_cmd_sd
    task automatic t_crc(logic [31:0] e, logic ok);
        for (int k = 0; k < 9; k++) begin
            @(posedge ref_clk);
            chk_data <= 8'h31 + 8'(k);
            chk_valid <= 1'b1;
            chk_first <= (k == 0);
            chk_last <= (k == 8);
            chk_expect <= e;
        end
        @(posedge ref_clk);
        chk_valid <= 1'b0;
        for (i = 0; i < 6 && chk_pass !== 1'b1 && integrity_fail !== 1'b1; i++) @(posedge ref_clk);
        chk("crc pass", 32'(ok), 32'(chk_pass));
        chk("crc fail", 32'(!ok), 32'(integrity_fail));
    endtask : t_crc
    task automatic t_reset();
        // pad held five cycles past the 250-cycle minimum
        reset_pad_n <= 1'b0;
        repeat (255) @(posedge ref_clk);
        chk("pad reset", 32'h0, 32'(wake_out));
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("port", 32'(PORT_SPI), 32'(host_port));
        chk("constel", 32'(CONSTEL_DEFAULT), 32'(constel_mask));
        rts_level <= 1'b1;
        reset_pad_n <= 1'b1;
        wait_wake();
        chk("strap port", 32'(PORT_UART), 32'(host_port));
    endtask : t_reset
    initial forever #2 ref_clk = ~ref_clk;
    // Watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        #80000;
        fails++;
        summarize();
    end
    initial begin
        msg0 = 120'h24_5053_5246_3135_302C_302A_3346_0D0A;
        msg1 = 120'h24_5053_5246_3135_302C_312A_3345_0D0A;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_startup();
        t_cmds();
        t_pin_sd();
        t_cmd_sd(CMD_NMEA_SHUTDOWN, 8'h00);
        t_cmd_sd(CMD_BINARY, MID_SHUTDOWN);
        t_crc(32'hCBF4_3926, 1'b1);
        t_crc(32'hCBF4_3927, 1'b0);
        t_reset();
        summarize();
    end
endmodule : tb_top
